/* File: verilog/fpp_ctrl.sv */
// Fuse programming controller: AXI4-Lite registers and pulse sequencer
// Operation
// - Hold tests two parameters, different zones
// - Zone 2 blow: key, bit, one high
// - Zone 1 blow ends with closing high pulses
// - One bit per blow, then cycle power
// - Lock train: 3H 2M 1H 4M 2H
// - Order coarse, sens, fine; lock last (blow order is not checked; only blows and a second lock after a lock are refused)
// - Unidirectional bit blown before hold testing (checked only for holds with the uni command bit set)
// - Try a code before blowing it
// - Hold low gap before removing power
// - Each pulse lasts the minimum active time
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`default_nettype none
module fpp_ctrl
  import fpp_pkg::*;
#(
  parameter int unsigned POWER_OFF_CYCLES = POWER_OFF_CYC,
  parameter int unsigned POWER_UP_CYCLES = POWER_UP_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output fpp_level_t prog_level,
  output logic supply_en
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OFF = 3'h1,
    ST_UP = 3'h2,
    ST_NEXT = 3'h3,
    ST_PULSE = 3'h4,
    ST_WAIT = 3'h5
  } fpp_state_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] OFF_LAST = 16'(POWER_OFF_CYCLES - 1);
  localparam logic [15:0] UP_LAST = 16'(POWER_UP_CYCLES - 1);

  // Write channel capture: address and data may arrive in either order
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [3:0] awaddr_r, wstrb_r;
  logic [31:0] wdata_r, rdata_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] cmd_r, arg_r;
  logic err_r, supply_r, tried_r, uni_blown_r, lock_sent_r;
  logic [15:0] pulses_r, timer_r;
  fpp_state_t state_r;
  fpp_mode_t mode_r;
  logic zone_r;
  fpp_args_t run_r;
  logic [2:0] idx_r;
  logic [8:0] left_r;
  logic [17:0] tried_key_r;

  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_got_r || aw_hs;
  wire w_have = w_got_r || w_hs;
  wire wr_fire = aw_have && w_have && !bvalid_r;
  wire [3:0] wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_got_r ? wdata_r : s_axi_wdata;
  wire [3:0] wr_strb = w_got_r ? wstrb_r : s_axi_wstrb;
  wire [1:0] wr_word = wr_addr[3:2];
  wire wr_cmd = wr_fire && (wr_word == CMD_OFFSET[3:2]);
  wire wr_arg = wr_fire && (wr_word == ARG_OFFSET[3:2]);
  wire wr_stat = wr_fire && (wr_word == STATUS_OFFSET[3:2]);
  wire wr_bad = wr_fire && !(wr_cmd || wr_arg || wr_stat);
  wire [1:0] rd_word = s_axi_araddr[3:2];
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire rd_bad = (rd_word == 2'h3);

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Command decode and the host-side checks made before any pulse goes out
  wire start_req = wr_cmd && wr_strb[0];
  wire fpp_mode_t req_mode = fpp_mode_t'(wr_data[CMD_MODE_LSB +: 3]);
  wire req_zone = wr_data[CMD_ZONE_BIT];
  wire req_uni = wr_data[CMD_UNI_BIT];
  wire req_confirm = wr_data[CMD_CONFIRM_BIT];
  wire fpp_args_t req_args = fpp_args_t'(arg_r);
  wire [7:0] code_a = req_args.code_a;
  wire key_is_coarse = req_zone && (req_args.key_a == KEY_COARSE);
  wire key_ok = req_zone ? (req_args.key_a == KEY_FINE || key_is_coarse)
                         : (req_args.key_a == KEY_SENS);
  wire coarse_ok = !key_is_coarse || (code_a == COARSE_UNI_CODE);
  wire single_bit = (code_a != 8'h00) && ((code_a & (code_a - 8'h01)) == 8'h00);
  wire [17:0] req_key = {7'h00, req_zone, req_args.key_a, code_a};
  wire was_tried = tried_r && (tried_key_r == req_key);
  wire busy = (state_r != ST_IDLE);
  logic req_ok;
  always_comb begin
    case (req_mode)
      FPP_MODE_TRY: req_ok = key_ok && coarse_ok;
      FPP_MODE_BLOW: req_ok = key_ok && coarse_ok && single_bit && was_tried && !lock_sent_r;
      FPP_MODE_HOLD: req_ok = !req_uni || uni_blown_r;
      FPP_MODE_LOCK: req_ok = req_confirm && !lock_sent_r;
      FPP_MODE_CYCLE: req_ok = 1'b1;
      FPP_MODE_OFF: req_ok = 1'b1;
      default: req_ok = 1'b0;
    endcase
  end
  wire start_ok = start_req && !busy && req_ok;
  wire start_refused = start_req && !(!busy && req_ok);

  // Segment table: each entry is a run of equal pulses, empty runs skipped
  function automatic fpp_seg_t seg_at(input fpp_mode_t m, input logic z,
                                      input fpp_args_t a, input logic [2:0] i);
    fpp_seg_t s;
    logic [8:0] entry;
    logic is_lock;
    logic is_blow;
    is_lock = (m == FPP_MODE_LOCK);
    is_blow = (m == FPP_MODE_BLOW);
    entry = (z || is_lock) ? ZONE2_ENTRY_HIGHS : ZONE1_ENTRY_HIGHS;
    s = '{level: FPP_LVL_LOW, blow: 1'b0, count: 9'h000};
    if (m == FPP_MODE_HOLD) begin
      case (i)
        3'h0: s = '{level: FPP_LVL_HIGH, blow: 1'b0, count: ZONE1_ENTRY_HIGHS};
        3'h1: s = '{level: FPP_LVL_MID, blow: 1'b0, count: {7'h00, KEY_SENS}};
        3'h2: s = '{level: FPP_LVL_HIGH, blow: 1'b0, count: SELECT_HIGHS};
        3'h3: s = '{level: FPP_LVL_MID, blow: 1'b0, count: {1'b0, a.code_a}};
        3'h4: s = '{level: FPP_LVL_HIGH, blow: 1'b0, count: SELECT_HIGHS};
        3'h5: s = '{level: FPP_LVL_MID, blow: 1'b0, count: {7'h00, KEY_FINE}};
        3'h6: s = '{level: FPP_LVL_HIGH, blow: 1'b0, count: SELECT_HIGHS};
        default: s = '{level: FPP_LVL_MID, blow: 1'b0, count: {1'b0, a.code_b}};
      endcase
    end else begin
      case (i)
        3'h0: s = '{level: FPP_LVL_HIGH, blow: 1'b0, count: entry};
        3'h1: s = '{level: FPP_LVL_MID, blow: 1'b0,
                    count: is_lock ? {7'h00, KEY_COARSE} : {7'h00, a.key_a}};
        3'h2: s = '{level: FPP_LVL_HIGH, blow: 1'b0, count: SELECT_HIGHS};
        3'h3: s = '{level: FPP_LVL_MID, blow: 1'b0,
                    count: is_lock ? {1'b0, LOCK_CODE} : {1'b0, a.code_a}};
        3'h4: begin
          if (is_lock) begin
            s = '{level: FPP_LVL_HIGH, blow: 1'b1, count: LOCK_TAIL_HIGHS};
          end else if (is_blow) begin
            s = '{level: FPP_LVL_HIGH, blow: 1'b1,
                  count: z ? ZONE2_BLOW_HIGHS : ZONE1_BLOW_HIGHS};
          end
        end
        default: s = '{level: FPP_LVL_LOW, blow: 1'b0, count: 9'h000};
      endcase
    end
    return s;
  endfunction : seg_at

  wire fpp_seg_t cur_seg = seg_at(mode_r, zone_r, run_r, idx_r);
  wire pg_start = (state_r == ST_PULSE) && !pg_busy;
  wire pg_done;
  wire pg_busy;
  wire timer_zero = (timer_r == 16'h0000);
  wire seq_last = (idx_r == 3'h7);
  wire pulse_last = (state_r == ST_WAIT) && pg_done && (left_r == 9'h001);
  wire seq_end = seq_last && (((state_r == ST_NEXT) && (cur_seg.count == 9'h000)) ||
                              pulse_last);
  wire burns = (mode_r == FPP_MODE_BLOW) || (mode_r == FPP_MODE_LOCK);

  fpp_pulse_gen u_pulse (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(pg_start),
    .level(cur_seg.level),
    .blow(cur_seg.blow),
    .pin_level(prog_level),
    .done(pg_done),
    .busy(pg_busy)
  );

  // Sequencer
  fpp_state_t state_nxt;
  logic [2:0] idx_nxt;
  logic [8:0] left_nxt;
  logic [15:0] timer_nxt;
  logic supply_nxt;
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    left_nxt = left_r;
    timer_nxt = timer_zero ? timer_r : timer_r - 16'h0001;
    supply_nxt = supply_r;
    case (state_r)
      ST_IDLE: begin
        if (start_ok) begin
          // Every mode but off starts from a fresh power-up so the device sits in its initial state
          supply_nxt = 1'b0;
          if (req_mode != FPP_MODE_OFF) begin
            state_nxt = ST_OFF;
            timer_nxt = OFF_LAST;
          end
        end
      end
      ST_OFF: begin
        if (timer_zero) begin
          state_nxt = ST_UP;
          supply_nxt = 1'b1;
          timer_nxt = UP_LAST;
        end
      end
      ST_UP: begin
        if (timer_zero) begin
          state_nxt = (mode_r == FPP_MODE_CYCLE) ? ST_IDLE : ST_NEXT;
          idx_nxt = 3'h0;
        end
      end
      ST_NEXT: begin
        if (cur_seg.count == 9'h000) begin
          idx_nxt = idx_r + 3'h1;
          state_nxt = seq_last ? ST_IDLE : ST_NEXT;
        end else begin
          left_nxt = cur_seg.count;
          state_nxt = ST_PULSE;
        end
      end
      ST_PULSE: begin
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (pg_done) begin
          left_nxt = left_r - 9'h001;
          if (left_r == 9'h001) begin
            idx_nxt = idx_r + 3'h1;
            state_nxt = seq_last ? ST_IDLE : ST_NEXT;
          end else begin
            state_nxt = ST_PULSE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Try and hold leave the supply on so the held value can be measured
    if (seq_end && burns) begin
      supply_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      idx_r <= 3'h0;
      left_r <= 9'h000;
      timer_r <= 16'h0000;
      supply_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      left_r <= left_nxt;
      timer_r <= timer_nxt;
      supply_r <= supply_nxt;
    end
  end

  // Command snapshot and session bookkeeping
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_r <= FPP_MODE_TRY;
      zone_r <= 1'b0;
      run_r <= fpp_args_t'(ARG_RESET);
      tried_r <= 1'b0;
      tried_key_r <= 18'h00000;
      uni_blown_r <= 1'b0;
      lock_sent_r <= 1'b0;
      pulses_r <= 16'h0000;
    end else begin
      if (start_ok) begin
        mode_r <= req_mode;
        zone_r <= req_zone;
        run_r <= req_args;
        pulses_r <= 16'h0000;
      end else if (pg_done) begin
        pulses_r <= pulses_r + 16'h0001;
      end
      if (start_ok && req_mode == FPP_MODE_TRY) begin
        tried_r <= 1'b1;
        tried_key_r <= req_key;
      end
      if (seq_end && mode_r == FPP_MODE_BLOW && zone_r && run_r.key_a == KEY_COARSE) begin
        uni_blown_r <= 1'b1;
      end
      if (seq_end && mode_r == FPP_MODE_LOCK) begin
        lock_sent_r <= 1'b1;
      end
    end
  end

  // Register file; a fresh refusal wins over a clear in the same cycle
  wire err_clr = wr_stat && wr_strb[0] && wr_data[ST_ERR_BIT];
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmd_r <= CMD_RESET;
      err_r <= 1'b0;
    end else begin
      if (start_req) begin
        cmd_r <= {24'h000000, wr_data[7:0]};
      end
      err_r <= start_refused || (err_r && !err_clr);
    end
  end

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_arg_lane
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          arg_r[8*b +: 8] <= ARG_RESET[8*b +: 8];
        end else if (wr_arg && wr_strb[b] && !busy) begin
          arg_r[8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  endgenerate

  wire [31:0] status_word = {pulses_r, 10'h000, lock_sent_r, uni_blown_r, tried_r, err_r,
                             supply_r, busy};
  wire [31:0] rd_mux = (rd_word == CMD_OFFSET[3:2]) ? cmd_r :
                       (rd_word == ARG_OFFSET[3:2]) ? arg_r :
                       (rd_word == STATUS_OFFSET[3:2]) ? status_word : 32'h0000_0000;

  // Bus handshakes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_got_r <= wr_fire ? 1'b0 : aw_have;
      w_got_r <= wr_fire ? 1'b0 : w_have;
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign supply_en = supply_r;
endmodule : fpp_ctrl
`default_nettype wire

/* File: verilog/fpp_pkg.sv */
// Shared constants, types and register map of the fuse programming controller
`default_nettype none
package fpp_pkg;
  // Timing, system clock rate and programming pulse figures
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned ACTIVE_TIME_US = 40;
  localparam int unsigned LOW_GAP_TIME_US = 40;
  localparam int unsigned BLOW_TIME_US = 40;
  localparam int unsigned POWER_OFF_TIME_US = 1000;
  localparam int unsigned POWER_UP_TIME_US = 1000;
  localparam int unsigned ACTIVE_CYC = (ACTIVE_TIME_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned LOW_GAP_CYC = (LOW_GAP_TIME_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned BLOW_CYC = (BLOW_TIME_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned POWER_OFF_CYC = (POWER_OFF_TIME_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned POWER_UP_CYC = (POWER_UP_TIME_US * CLK_HZ + 999_999) / 1_000_000;

  // Pulse sequence figures
  localparam logic [8:0] ZONE1_ENTRY_HIGHS = 9'h001;
  localparam logic [8:0] ZONE2_ENTRY_HIGHS = 9'h003;
  localparam logic [8:0] SELECT_HIGHS = 9'h001;
  localparam logic [8:0] ZONE1_BLOW_HIGHS = 9'h002;
  localparam logic [8:0] ZONE2_BLOW_HIGHS = 9'h001;
  localparam logic [8:0] LOCK_TAIL_HIGHS = 9'h002;
  localparam logic [1:0] KEY_SENS = 2'h1;
  localparam logic [1:0] KEY_FINE = 2'h1;
  localparam logic [1:0] KEY_COARSE = 2'h2;
  localparam logic [7:0] COARSE_UNI_CODE = 8'h01;
  localparam logic [7:0] LOCK_CODE = 8'h04;

  // Register byte offsets
  localparam logic [3:0] CMD_OFFSET = 4'h0;
  localparam logic [3:0] ARG_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  // Command register fields
  localparam int CMD_MODE_LSB = 0;
  localparam int CMD_ZONE_BIT = 4;
  localparam int CMD_UNI_BIT = 5;
  localparam int CMD_CONFIRM_BIT = 6;
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  localparam logic [31:0] ARG_RESET = 32'h0000_0000;
  // Status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SUPPLY_BIT = 1;
  localparam int ST_ERR_BIT = 2;
  localparam int ST_TRIED_BIT = 3;
  localparam int ST_UNI_BIT = 4;
  localparam int ST_LOCK_BIT = 5;
  localparam int ST_PULSES_LSB = 16;

  typedef enum logic [1:0] {
    FPP_LVL_LOW = 2'h0,
    FPP_LVL_MID = 2'h1,
    FPP_LVL_HIGH = 2'h2
  } fpp_level_t;

  typedef enum logic [2:0] {
    FPP_MODE_TRY = 3'h0,
    FPP_MODE_BLOW = 3'h1,
    FPP_MODE_HOLD = 3'h2,
    FPP_MODE_LOCK = 3'h3,
    FPP_MODE_CYCLE = 3'h4,
    FPP_MODE_OFF = 3'h5
  } fpp_mode_t;

  typedef struct packed {
    logic [7:0] code_b;
    logic [5:0] pad_b;
    logic [1:0] key_b;
    logic [7:0] code_a;
    logic [5:0] pad_a;
    logic [1:0] key_a;
  } fpp_args_t;

  typedef struct packed {
    fpp_level_t level;
    logic blow;
    logic [8:0] count;
  } fpp_seg_t;
endpackage : fpp_pkg
`default_nettype wire

/* File: verilog/fpp_pulse_gen.sv */
// One programming pulse on the sense output pin followed by its low gap
`default_nettype none
module fpp_pulse_gen
  import fpp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic start,
  input wire fpp_level_t level,
  input wire logic blow,
  output fpp_level_t pin_level,
  output logic done,
  output logic busy
);
  typedef enum logic [1:0] {
    PG_IDLE = 2'h0,
    PG_DRIVE = 2'h1,
    PG_GAP = 2'h2
  } fpp_pg_state_t;

  localparam logic [10:0] ACT_LAST = 11'(ACTIVE_CYC - 1);
  localparam logic [10:0] BLOW_LAST = 11'(BLOW_CYC - 1);
  localparam logic [10:0] GAP_LAST = 11'(LOW_GAP_CYC - 1);

  fpp_pg_state_t state_r, state_nxt;
  logic [10:0] timer_r, timer_nxt;
  fpp_level_t level_r, level_nxt;
  wire timer_zero = (timer_r == 11'h000);

  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    level_nxt = level_r;
    case (state_r)
      PG_IDLE: begin
        if (start) begin
          state_nxt = PG_DRIVE;
          level_nxt = level;
          timer_nxt = blow ? BLOW_LAST : ACT_LAST;
        end
      end
      PG_DRIVE: begin
        if (timer_zero) begin
          state_nxt = PG_GAP;
          level_nxt = FPP_LVL_LOW;
          timer_nxt = GAP_LAST;
        end else begin
          timer_nxt = timer_r - 11'h001;
        end
      end
      PG_GAP: begin
        if (timer_zero) begin
          state_nxt = PG_IDLE;
        end else begin
          timer_nxt = timer_r - 11'h001;
        end
      end
      default: begin
        state_nxt = PG_IDLE;
        level_nxt = FPP_LVL_LOW;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= PG_IDLE;
      timer_r <= 11'h000;
      level_r <= FPP_LVL_LOW;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      level_r <= level_nxt;
    end
  end

  assign pin_level = level_r;
  assign done = (state_r == PG_GAP) && timer_zero;
  assign busy = (state_r != PG_IDLE);
endmodule : fpp_pulse_gen
`default_nettype wire

/* File: dv/fpp_ctrl_properties.sv */
// Port-level checks of the fuse programming controller
`default_nettype none
module fpp_ctrl_properties
  import fpp_pkg::*;
#(
  parameter int unsigned POWER_OFF_CYCLES = 20,
  parameter int unsigned POWER_UP_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire fpp_level_t prog_level,
  input wire logic supply_en
);
  logic [15:0] act_cnt;
  logic [15:0] low_cnt;
  wire lvl_low = prog_level == FPP_LVL_LOW;
  wire low_top = low_cnt == 16'hffff;
  // Gap counter starts saturated so the first pulse after reset is not judged
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      act_cnt <= 16'h0000;
      low_cnt <= 16'hffff;
    end else begin
      act_cnt <= lvl_low ? 16'h0000 : act_cnt + 16'h0001;
      low_cnt <= !lvl_low ? 16'h0000 : (low_top ? low_cnt : low_cnt + 16'h0001);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence off_run_s;
    !supply_en [*8];
  endsequence
  sequence quiet_up_s;
    lvl_low [*8];
  endsequence
  pwr_off_hold_a: assert property ($fell(supply_en) |-> off_run_s)
    else $error("supply off too short");
  pwr_up_quiet_a: assert property ($rose(supply_en) |-> quiet_up_s)
    else $error("pulse too soon after power up");
  pulse_width_a: assert property ((lvl_low && act_cnt != 0) |-> act_cnt >= ACTIVE_CYC)
    else $error("pulse too short");
  level_steady_a: assert property ((!lvl_low && act_cnt != 0) |-> $stable(prog_level))
    else $error("level changed within pulse");
  low_gap_a: assert property ((!lvl_low && act_cnt == 0) |-> low_cnt >= LOW_GAP_CYC)
    else $error("low gap too short");
  drop_gap_a: assert property ($fell(supply_en) |-> lvl_low && low_cnt >= LOW_GAP_CYC)
    else $error("supply dropped before low gap");
  write_resp_a: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready) |=> s_axi_bvalid)
    else $error("no write response");
  unmapped_rd_a: assert property ((s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'h3)
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule : fpp_ctrl_properties

bind fpp_ctrl fpp_ctrl_properties #(
  .POWER_OFF_CYCLES(POWER_OFF_CYCLES),
  .POWER_UP_CYCLES(POWER_UP_CYCLES)
) u_props (
  .sys_clk(sys_clk),
  .srst(srst),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .prog_level(prog_level),
  .supply_en(supply_en)
);
`default_nettype wire

/* File: dv/fpp_dev_model.sv */
// Behavioural model of the sensor's pulse-decoded trim logic
`default_nettype none
module fpp_dev_model
  import fpp_pkg::*;
(
  input wire logic sys_clk,
  input wire fpp_level_t prog_level,
  input wire logic supply_en,
  output logic [7:0] sens_v,
  output logic [7:0] fine_v,
  output logic [7:0] coarse_v,
  output logic locked
);
  typedef enum logic [2:0] {
    FPP_D_INIT, FPP_D_SEL1, FPP_D_BIT1, FPP_D_SKIP, FPP_D_SEL2, FPP_D_BIT2, FPP_D_DONE
  } fpp_dstate_t;
  fpp_dstate_t st_r;
  fpp_level_t last_r;
  logic [1:0] key_r;
  logic [7:0] code_r [4];
  logic [7:0] fuse_r [4];
  wire ended = supply_en && last_r != FPP_LVL_LOW && prog_level == FPP_LVL_LOW;
  wire [1:0] idx = st_r == FPP_D_BIT2 ? key_r : 2'h0;
  wire fire = st_r == FPP_D_BIT2 || (st_r == FPP_D_SEL2 && key_r == 2'h0);
  wire uni_sel = coarse_v == COARSE_UNI_CODE;
  assign sens_v = fuse_r[0] | code_r[0];
  assign fine_v = fuse_r[1] | code_r[1];
  assign coarse_v = fuse_r[2] | code_r[2];
  assign locked = fuse_r[2][2];
  // Fuses survive power loss, so only time zero clears them
  initial for (int i = 0; i < 4; i++) fuse_r[i] = 8'h00;
  always @(posedge sys_clk) begin
    last_r <= prog_level;
    if (!supply_en) begin
      st_r <= FPP_D_INIT;
      key_r <= 2'h0;
      for (int i = 0; i < 4; i++) code_r[i] <= 8'h00;
    end else if (ended && last_r == FPP_LVL_MID) begin
      if (st_r == FPP_D_SEL1 || st_r == FPP_D_SEL2) key_r <= key_r + 2'h1;
      else if ((st_r == FPP_D_BIT1 || st_r == FPP_D_BIT2) && code_r[idx] != 8'hff)
        code_r[idx] <= code_r[idx] + 8'h01;
    end else if (ended) begin
      case (st_r)
        FPP_D_INIT: st_r <= FPP_D_SEL1;
        FPP_D_SEL1: st_r <= key_r == 2'h0 ? FPP_D_SKIP : FPP_D_BIT1;
        FPP_D_SKIP, FPP_D_BIT1: begin
          st_r <= FPP_D_SEL2;
          key_r <= 2'h0;
        end
        FPP_D_SEL2: st_r <= key_r == 2'h0 ? FPP_D_DONE : FPP_D_BIT2;
        default: st_r <= FPP_D_DONE;
      endcase
      if (fire && !locked) fuse_r[idx] <= fuse_r[idx] | code_r[idx];
    end
  end
endmodule : fpp_dev_model
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the fuse programming controller
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench
  import fpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  fpp_level_t prog_level;
  logic supply_en, locked;
  logic [7:0] sens_v, fine_v, coarse_v;
  int errors = 0;
  int cmp_count = 0;
  fpp_ctrl #(.POWER_OFF_CYCLES(20), .POWER_UP_CYCLES(20)) uut (.sys_clk(sys_clk), .srst(srst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .prog_level(prog_level),
    .supply_en(supply_en));
  fpp_dev_model u_dev (.sys_clk(sys_clk), .prog_level(prog_level), .supply_en(supply_en),
    .sens_v(sens_v), .fine_v(fine_v), .coarse_v(coarse_v), .locked(locked));

  task automatic complete_run;
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // Answers are read at the rising edge that takes them
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic st(output logic [31:0] d);
    logic [1:0] r;
    rd(STATUS_OFFSET, d, r);
  endtask : st

  task automatic go(input logic [31:0] arg, input logic [7:0] cmd);
    logic [1:0] r;
    logic [31:0] d;
    int n;
    wr(ARG_OFFSET, arg, r);
    wr(CMD_OFFSET, {24'h000000, cmd}, r);
    n = 0;
    d = 32'h0000_0001;
    while (d[ST_BUSY_BIT] !== 1'h0 && n < 20000) begin
      st(d);
      n++;
    end
    if (n >= 20000) begin
      errors++;
      complete_run();
    end
  endtask : go

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    st(d);
    `CHK("status", 32'h0000_0000, d);
    `CHK("sens", 8'h00, sens_v);
    rd(4'hc, d, r);
    `CHK("unmapped rresp", 2'h2, r);
    wr(4'hc, 32'h0000_0001, r);
    `CHK("unmapped bresp", 2'h2, r);
  endtask : t_reset

  task automatic t_try;
    logic [31:0] d;
    go(32'h0000_0201, 8'h00);
    st(d);
    `CHK("try sens", 8'h02, sens_v);
    `CHK("try supply", 1'h1, supply_en);
    `CHK("try pulses", 16'h0005, d[31:16]);
    `CHK("tried", 1'h1, d[ST_TRIED_BIT]);
    go(32'h0000_0101, 8'h10);
    `CHK("sens cleared", 8'h00, sens_v);
    `CHK("try fine", 8'h01, fine_v);
  endtask : t_try

  task automatic t_refuse;
    logic [7:0] cmds [4];
    logic [31:0] d;
    logic [1:0] r;
    cmds = '{8'h11, 8'h22, 8'h03, 8'h06};
    wr(ARG_OFFSET, 32'h0000_0301, r);
    foreach (cmds[i]) begin
      wr(CMD_OFFSET, {24'h000000, cmds[i]}, r);
      st(d);
      `CHK("refused", 2'h2, {d[ST_ERR_BIT], d[ST_BUSY_BIT]});
      wr(STATUS_OFFSET, 32'h0000_0004, r);
    end
    st(d);
    `CHK("err clear", 1'h0, d[ST_ERR_BIT]);
    `CHK("fine kept", 8'h01, fine_v);
  endtask : t_refuse

  task automatic t_blow_hold;
    go(32'h0000_0101, 8'h11);
    `CHK("blow supply", 1'h0, supply_en);
    `CHK("blown fine", 8'h01, fine_v);
    go(32'h0000_0201, 8'h02);
    `CHK("hold sens", 8'h02, sens_v);
    `CHK("hold fine", 8'h01, fine_v);
  endtask : t_blow_hold

  task automatic t_lock;
    logic [31:0] d;
    logic [1:0] r;
    go(32'h0000_0000, 8'h43);
    st(d);
    `CHK("locked", 1'h1, locked);
    `CHK("lock flag", 1'h1, d[ST_LOCK_BIT]);
    `CHK("lock code", 8'h04, coarse_v);
    wr(ARG_OFFSET, 32'h0000_0101, r);
    wr(CMD_OFFSET, 32'h0000_0011, r);
    st(d);
    `CHK("blow after lock", 1'h1, d[ST_ERR_BIT]);
  endtask : t_lock

  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Whole sequence needs about 76k cycles of pulses
  initial begin
    repeat (98000) @(posedge sys_clk);
    errors++;
    complete_run();
  end

  initial begin
    srst = 1'h1;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge sys_clk);
    srst <= 1'h0;
    t_reset();
    t_try();
    t_refuse();
    t_blow_hold();
    t_lock();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
